// ### rtl/adc_seq_pkg.sv
// package: constants and carriers of the serial converter frame sequencer
package adc_seq_pkg;

  // slot framing, counted in internal serial clock edges
  localparam int SLOT_CLOCKS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] FIRST_FALL = 5'h01;
  localparam logic [CNT_W-1:0] HOLD_FALL = 5'h04;
  localparam logic [CNT_W-1:0] SLOT_LAST_FALL = 5'h10;
  localparam logic [CNT_W-1:0] SLOT_LAST_RISE = 5'h10;
  localparam logic [CNT_W-1:0] CTRL_LAST_RISE = 5'h08;
  // msb is driven after the 5th fall, so the host reads it on rise 5;
  // this also leaves the core a whole clock after hold entry to deliver
  localparam logic [CNT_W-1:0] MSB_FALL = 5'h05;

  // result and control word layout
  localparam int RESULT_BITS = 10;
  localparam int CTRL_BITS = 8;
  localparam int CHAN_SEL_BIT0 = 3;
  localparam int CHAN_SEL_BIT1 = 4;
  localparam int CHAN_SEL_BIT2 = 5;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'h00;
  localparam logic CHAN_RESET = 1'h0;
  localparam logic [CNT_W-1:0] RESULT_LAST_FALL = 5'h0E;

  // pin input synchroniser depth
  localparam int SYNC_STAGES = 3;

  // slot phase, gray coded along idle, track, hold, gap
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_TRACK = 2'b01,
    PH_HOLD = 2'b11,
    PH_GAP = 2'b10
  } phase_e;

  // the three serial input pins travel together
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdin;
  } pins_s;

  localparam pins_s PINS_IDLE = 3'h4;

  // one conversion result from the analog core
  typedef struct packed {
    logic [RESULT_BITS-1:0] code;
  } conv_word_s;

  localparam conv_word_s WORD_ZERO = 10'h000;

endpackage

// ### rtl/dual_channel_adc_serial_sequencer.sv
// serial frame sequencer of a two-input converter: pins, slot timing, result shift-out
module dual_channel_adc_serial_sequencer
  import adc_seq_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // serial pins
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // analog core control
  output logic track_en,
  output logic track_chan_b,
  output logic power_down,
  output logic sample_req,
  output logic sample_chan_b,
  // conversion results from the analog core
  input wire logic conv_valid,
  input wire conv_word_s conv_word,
  output logic conv_ready
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(BUF_DEPTH);
  localparam logic [PTR_W:0] FILL_ZERO = '0;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);

  // pointer wrap logic serves power-of-two depths of two or more
  generate
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("BUF_DEPTH must be a power of two, at least 2");
    end
  endgenerate

  // result bit for the clock that follows fall number cnt
  function automatic logic result_bit(
    input logic [CNT_W-1:0] cnt,
    input logic loaded,
    input conv_word_s word
  );
    logic [CNT_W-1:0] idx;
    idx = cnt - MSB_FALL;
    result_bit = 1'b0;
    if (loaded && cnt >= MSB_FALL && cnt <= RESULT_LAST_FALL) begin
      result_bit = word.code[RESULT_BITS - 1 - int'(idx)];
    end
  endfunction

  // ---------------- pin synchronisers ----------------
  pins_s sync1_reg;
  pins_s sync2_reg;
  pins_s sync3_reg;
  pins_s filt_reg;
  pins_s filt_next;
  pins_s filt_d_reg;
  pins_s agree;

  // three stages; a level counts once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign filt_next = (sync3_reg & agree) | (filt_reg & ~agree);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_reg <= PINS_IDLE;
      sync2_reg <= PINS_IDLE;
      sync3_reg <= PINS_IDLE;
    end else begin
      sync1_reg <= '{frame_n: frame_sel_n, sclk: serial_clk, sdin: serial_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // filtered level and its previous value for edge finding
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_reg <= PINS_IDLE;
      filt_d_reg <= PINS_IDLE;
    end else begin
      filt_reg <= filt_next;
      filt_d_reg <= filt_reg;
    end
  end

  // ---------------- internal serial clock ----------------
  logic frame;
  logic frame_fall;
  logic sclk_fall;
  logic sclk_rise;
  logic int_fall;
  logic int_rise;

  assign frame = ~filt_reg.frame_n;
  assign frame_fall = filt_d_reg.frame_n & ~filt_reg.frame_n;
  assign sclk_fall = filt_d_reg.sclk & ~filt_reg.sclk;
  assign sclk_rise = ~filt_d_reg.sclk & filt_reg.sclk;
  // gated: no edge counts outside a frame
  assign int_rise = frame & sclk_rise;
  // clock resting low: the select fall itself is the first fall
  assign int_fall = (frame & sclk_fall) | (frame_fall & ~filt_reg.sclk);

  // ---------------- slot counters ----------------
  logic [CNT_W-1:0] fall_cnt_reg;
  logic [CNT_W-1:0] fall_cnt_next;
  logic [CNT_W-1:0] rise_cnt_reg;
  logic [CNT_W-1:0] rise_cnt_next;
  logic slot_start;

  // a fall after the 16th (or the first of a frame) opens a new slot
  assign slot_start = int_fall & (fall_cnt_reg == CNT_ZERO || fall_cnt_reg == SLOT_LAST_FALL);
  assign fall_cnt_next = !frame ? CNT_ZERO :
                         slot_start ? FIRST_FALL :
                         int_fall ? fall_cnt_reg + CNT_ONE : fall_cnt_reg;
  // rises restart at each slot; stray extra rises saturate at 16
  assign rise_cnt_next = (!frame || slot_start) ? CNT_ZERO :
                         (int_rise && rise_cnt_reg != SLOT_LAST_RISE) ? rise_cnt_reg + CNT_ONE :
                         rise_cnt_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fall_cnt_reg <= CNT_ZERO;
      rise_cnt_reg <= CNT_ZERO;
    end else begin
      fall_cnt_reg <= fall_cnt_next;
      rise_cnt_reg <= rise_cnt_next;
    end
  end

  // ---------------- slot phase ----------------
  phase_e phase_reg;
  phase_e phase_next;

  // a partial slot is abandoned as soon as select rises
  always_comb begin
    phase_next = phase_reg;
    if (!frame) begin
      phase_next = PH_IDLE;
    end else if (int_fall) begin
      unique case (fall_cnt_next)
        FIRST_FALL: phase_next = PH_TRACK;
        HOLD_FALL: phase_next = PH_HOLD;
        SLOT_LAST_FALL: phase_next = PH_GAP;
        default: phase_next = phase_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ---------------- control word capture ----------------
  logic [CTRL_BITS-1:0] ctrl_shift_reg;
  logic [CTRL_BITS-1:0] ctrl_shift_next;
  logic [CTRL_BITS-1:0] next_channel_control_word_reg;
  logic ctrl_take;
  logic ctrl_done;
  logic chan_pending;
  logic active_chan_reg;

  // only the first eight rises of a slot shift, msb first
  assign ctrl_take = int_rise & (rise_cnt_reg < CTRL_LAST_RISE);
  assign ctrl_done = ctrl_take & (rise_cnt_next == CTRL_LAST_RISE);
  assign ctrl_shift_next = {ctrl_shift_reg[CTRL_BITS-2:0], filt_reg.sdin};
  // bit 4 set is illegal, so bit 3 alone picks the input;
  // bits 7, 6, 5 and 2 to 0 are never looked at
  assign chan_pending = next_channel_control_word_reg[CHAN_SEL_BIT0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_shift_reg <= CTRL_RESET;
    end else if (ctrl_take) begin
      ctrl_shift_reg <= ctrl_shift_next;
    end
  end

  // whole word kept until the eighth rise of a later slot replaces it, across frames too
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      next_channel_control_word_reg <= CTRL_RESET;
    end else if (ctrl_done) begin
      next_channel_control_word_reg <= ctrl_shift_next;
    end
  end

  // choice made in one slot steers the following one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_chan_reg <= CHAN_RESET;
    end else if (frame && slot_start) begin
      active_chan_reg <= chan_pending;
    end
  end

  // ---------------- analog core control ----------------
  logic hold_entry;

  assign hold_entry = frame & int_fall & (fall_cnt_next == HOLD_FALL) & ~slot_start;

  // registered so the core sees clean levels
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      track_en <= 1'b0;
      power_down <= 1'b1;
      sample_req <= 1'b0;
    end else begin
      track_en <= (phase_next == PH_TRACK);
      power_down <= (phase_next == PH_IDLE) || (phase_next == PH_GAP);
      sample_req <= hold_entry;
    end
  end

  // channel goes out with the track phase and with the sample pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      track_chan_b <= CHAN_RESET;
      sample_chan_b <= CHAN_RESET;
    end else begin
      track_chan_b <= (frame && slot_start) ? chan_pending : active_chan_reg;
      sample_chan_b <= hold_entry ? active_chan_reg : sample_chan_b;
    end
  end

  // ---------------- two-entry result buffer ----------------
  conv_word_s buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] fill_reg;
  logic buf_push;
  logic buf_pop;
  logic buf_empty;
  logic want_word;
  logic res_loaded_reg;

  // the core stalls while both entries hold unread words
  assign conv_ready = (fill_reg != DEPTH_CNT);
  assign buf_empty = (fill_reg == FILL_ZERO);
  assign buf_push = conv_valid & conv_ready;
  assign want_word = frame & (phase_reg == PH_HOLD) & ~res_loaded_reg;
  assign buf_pop = want_word & ~buf_empty;

  always_ff @(posedge clock) begin
    if (buf_push) begin
      buf_mem[wr_ptr_reg] <= conv_word;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= FILL_ZERO;
    end else begin
      wr_ptr_reg <= buf_push ? ((wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= buf_pop ? ((rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1) : rd_ptr_reg;
      fill_reg <= fill_reg + (PTR_W + 1)'(buf_push) - (PTR_W + 1)'(buf_pop);
    end
  end

  // ---------------- result shift-out ----------------
  conv_word_s res_reg;
  logic dout_next;

  // one word per slot; dropped when the slot ends or select rises
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      res_reg <= WORD_ZERO;
      res_loaded_reg <= 1'b0;
    end else if (!frame || slot_start) begin
      res_loaded_reg <= 1'b0;
    end else if (buf_pop) begin
      res_reg <= buf_mem[rd_ptr_reg];
      res_loaded_reg <= 1'b1;
    end
  end

  // bit index follows the fall count, so the pin only moves after falls;
  // zeros lead and trail the ten result bits
  assign dout_next = frame & result_bit(fall_cnt_reg, res_loaded_reg, res_reg);

  // select high releases the pin, select low drives it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out <= dout_next;
      serial_out_oe_n <= filt_reg.frame_n;
    end
  end

endmodule

// ### tb/adc_seq_props.sv
// checker: timing relations on the converter sequencer's pins
module adc_seq_props
  import adc_seq_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // serial pins
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  // analog core side
  input wire logic track_en,
  input wire logic track_chan_b,
  input wire logic power_down,
  input wire logic sample_req,
  input wire logic sample_chan_b,
  input wire logic conv_valid,
  input wire conv_word_s conv_word,
  input wire logic conv_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // windows of 8 cycles cover the pin synchroniser latency
  oe_idle_a: assert property (frame_sel_n [*8] |-> serial_out_oe_n) else $error("output enabled outside frame");
  oe_frame_a: assert property (!frame_sel_n [*8] |-> !serial_out_oe_n) else $error("output off inside frame");
  pd_idle_a: assert property (frame_sel_n [*8] |-> power_down && !track_en) else $error("active outside frame");
  out_quiet_a: assert property (serial_out_oe_n [*3] |-> !serial_out) else $error("result pin not zero");
  track_run_a: assert property ($rose(track_en) |-> track_en [*8]) else $error("track phase too short");
  track_up_a: assert property (track_en |-> !power_down) else $error("tracking while powered down");
  hold_entry_a: assert property (sample_req |-> !track_en && $past(track_en) && !power_down)
    else $error("hold entered out of track");
  req_pulse_a: assert property (sample_req |=> !sample_req) else $error("sample request too long");
  chan_move_a: assert property ($changed(track_chan_b) |-> track_en) else $error("channel moved outside track");
  chan_held_a: assert property (sample_req |-> sample_chan_b == $past(track_chan_b))
    else $error("held channel differs from tracked");
  // hold lasts twelve serial periods, about 188 system cycles
  gap_down_a: assert property ($fell(track_en) |-> ##[150:200] power_down)
    else $error("no power down after slot");

  // main scenarios reached
  sample_c: cover property (sample_req);
  track_c: cover property ($rose(track_en));
  push_c: cover property (conv_valid && conv_ready);
  gap_c: cover property ($rose(power_down) && !serial_out_oe_n);
endmodule

// ### tb/serial_host_model.sv
// host serial master: frames two 16-clock slots and collects the result bits
module serial_host_model (
  // control from the bench
  input wire logic start,
  input wire logic idle_hi,
  input wire logic [7:0] ctrl0,
  input wire logic [7:0] ctrl1,
  // device pins
  input wire logic serial_out,
  output logic frame_sel_n,
  output logic serial_clk,
  output logic serial_in,
  // collected words
  output logic done,
  output logic [15:0] res0,
  output logic [15:0] res1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] shift;
  logic [7:0] word;

  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    done = 1'b0;
  end

  // one frame of exactly two slots, 125 ns serial period;
  // non-blocking, so a pin change landing on a system edge is seen after it
  always @(posedge start) begin
    done <= 1'b0;
    serial_clk <= idle_hi;
    #100;
    frame_sel_n <= 1'b0;
    // select and clock falls kept well apart
    if (idle_hi) #62;
    for (int s = 0; s < 2; s++) begin
      word = s ? ctrl1 : ctrl0;
      for (int i = 0; i < 16; i++) begin
        serial_clk <= 1'b0;
        // control bits msb first ahead of rises 1..8, then a changing filler
        serial_in <= (i < 8) ? word[7-i] : ~serial_in;
        #62;
        serial_clk <= 1'b1;
        shift = {shift[14:0], serial_out};
        #63;
      end
      if (s == 0) res0 = shift;
      else res1 = shift;
    end
    frame_sel_n <= 1'b1;
    // released data line must not look like a held value
    serial_in <= ~serial_in;
    #10;
    serial_clk <= idle_hi;
    done <= 1'b1;
  end
endmodule

// ### tb/dual_channel_adc_serial_sequencer_tb.sv
// testbench: frames through a host model, core answers with fixed codes
module dual_channel_adc_serial_sequencer_tb;
  import adc_seq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] CODE_A = 10'h2A5;
  localparam logic [9:0] CODE_B = 10'h15A;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic frame_sel_n, serial_clk, serial_in, serial_out, serial_out_oe_n;
  logic track_en, track_chan_b, power_down, sample_req, sample_chan_b;
  logic conv_valid = 1'b0;
  conv_word_s conv_word = WORD_ZERO;
  logic conv_ready;
  logic start = 1'b0;
  logic idle_hi = 1'b0;
  logic [7:0] ctrl0 = 8'h00;
  logic [7:0] ctrl1 = 8'h00;
  logic done;
  logic [15:0] res0, res1;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  dual_channel_adc_serial_sequencer uut (.clock, .sys_rst, .frame_sel_n, .serial_clk, .serial_in,
    .serial_out, .serial_out_oe_n, .track_en, .track_chan_b, .power_down, .sample_req,
    .sample_chan_b, .conv_valid, .conv_word, .conv_ready);

  serial_host_model host (.start, .idle_hi, .ctrl0, .ctrl1, .serial_out, .frame_sel_n,
    .serial_clk, .serial_in, .done, .res0, .res1);

  // core stand-in: one word per sample request, held until taken
  always @(posedge clock) begin
    if (sys_rst) begin
      conv_valid <= 1'b0;
    end else if (sample_req) begin
      conv_valid <= 1'b1;
      conv_word.code <= sample_chan_b ? CODE_B : CODE_A;
    end else if (conv_valid && conv_ready) begin
      conv_valid <= 1'b0;
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected slot word: four leading zeros, ten result bits, two trailing zeros
  function automatic logic [15:0] slot_word(input logic [9:0] code);
    return {4'h0, code, 2'h0};
  endfunction

  // one two-slot frame, bounded wait for the host
  task automatic run_frame(input logic hi, input logic [7:0] c0, input logic [7:0] c1);
    idle_hi <= hi;
    ctrl0 <= c0;
    ctrl1 <= c1;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    for (int k = 0; k < 1200 && done !== 1'b1; k++) @(posedge clock);
    // a host that never finishes counts as a mismatch
    check({15'h0, done}, 16'h0001);
    repeat (20) @(posedge clock);
  endtask

  // clock resting low, first slot after reset, ignored bits set
  task automatic t_first_frame();
    run_frame(1'b0, 8'hEF, 8'h00);
    check(res0, slot_word(CODE_A));
    check(res1, slot_word(CODE_B));
  endtask

  // clock resting high, bit 5 alone leaves the first input
  task automatic t_clock_high();
    run_frame(1'b1, 8'h20, 8'h08);
    check(res0, slot_word(CODE_A));
    check(res1, slot_word(CODE_A));
  endtask

  // choice of the last slot carries into the next frame
  task automatic t_pending_kept();
    run_frame(1'b0, 8'h00, 8'h00);
    check(res0, slot_word(CODE_B));
    check(res1, slot_word(CODE_A));
  endtask

  // between frames: output released, powered down, not tracking
  task automatic t_idle();
    repeat (10) @(posedge clock);
    check({13'h0, serial_out_oe_n, power_down, track_en}, 16'h0006);
    check({15'h0, serial_out}, 16'h0000);
  endtask

  // hang guard, generous over three frames
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_first_frame();
    t_idle();
    t_clock_high();
    t_pending_kept();
    t_idle();
    end_sim();
  end
endmodule

bind dual_channel_adc_serial_sequencer adc_seq_props chk (.clock, .sys_rst, .frame_sel_n, .serial_clk,
  .serial_in, .serial_out, .serial_out_oe_n, .track_en, .track_chan_b, .power_down, .sample_req,
  .sample_chan_b, .conv_valid, .conv_word, .conv_ready);
